// ===== rtl/sor_release.sv
// Purpose: Release and latching of the two safety outputs
// Assumes: Inputs synchronous to clk except buttons; bus is Avalon-MM
// Notes:   Outputs are registered; error flag held in retained storage
`timescale 1ns/1ps
// How it works
// - After power-up outputs stay off, indicator blinks at 5 Hz.
// - Auto variant releases both outputs on closed feedback level.
// - Monitored variant ignores feedback alone; reset button needed.
// - Monitored variant acts on reset button falling edge only.
// - Inputs dropping apart over 500 ms switch off and flag error.
// - No release while the discrepancy error is unacknowledged.
// - Discrepancy error kept in storage across power loss.
// - Acknowledge by input falling edge or serial command.
// - Warning byte bit 6 reports a serial communication fault.
// - Request bit 6 falling from 1 to 0 clears discrepancy error.
// - Internal error cleared by request bit 7 fall or guard open.
module sor_release #(
  parameter int BLINK_HALF = sor_pkg::BLINK_HALF_CYC,
  parameter int DISC_LIMIT = sor_pkg::DISC_CYC
) (
  input  wire logic        clk,               // 125 MHz clock
  input  wire logic        rst_n,             // Async reset, active low
  input  wire logic        safety_input_a,    // Safety input A, high live
  input  wire logic        safety_input_b,    // Safety input B, high live
  input  wire logic        actuated,          // Actuator detected
  input  wire logic        feedback_closed,   // Feedback circuit closed
  input  wire logic        reset_button,      // Reset button, idles high
  input  wire logic        ack_button,        // Acknowledge, idles high
  input  wire logic        internal_fault,    // Internal error cause
  input  wire logic        nv_disc_err,       // Retained error at power-up
  output logic             nv_disc_err_w,     // Error value to retain
  output logic             safety_output_a,   // Safety output A
  output logic             safety_output_b,   // Safety output B
  output logic             status_led,        // Yellow indicator
  output logic             irq,               // Level interrupt
  input  wire logic [3:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read strobe
  input  wire logic        avs_write,         // Write strobe
  input  wire logic [31:0] avs_writedata,     // Write data
  input  wire logic [3:0]  avs_byteenable,    // Byte enables
  output logic [31:0]      avs_readdata,      // Read data
  output logic             avs_waitrequest    // Wait request
);
  // Refuse timing values the counters cannot serve; the blink divider
  // needs one cycle per half period and the discrepancy timer must
  // count past its start value of one
  if (BLINK_HALF < 1 || DISC_LIMIT < 2) begin : g_bad_timing
    $error("sor_release: timing parameters too small");
  end

  localparam int DW = $clog2(DISC_LIMIT + 1);
  localparam int BW = $clog2(BLINK_HALF + 1);

  sor_pkg::sor_state_t state_q;
  logic [4:0]      ctrl_q;
  logic            req_ack_prev_q;
  logic            req_rst_prev_q;
  logic            int_err_q;
  logic [DW-1:0]   disc_cnt_q;
  logic            disc_run_q;
  logic            disc_hit;
  logic [BW-1:0]   blink_cnt_q;
  logic            blink_q;
  logic [3:0]      irq_st_q;
  logic [3:0]      irq_mk_q;
  logic [3:0]      ev;
  logic            rst_lvl;
  logic            rst_fall;
  logic            ack_lvl;
  logic            ack_fall;
  logic            disc_err;
  logic            disc_clr;
  logic            ser_ack;
  logic            ser_rst;
  logic            guard_open;
  logic            may_release;
  logic            go;
  logic            out_d;
  logic [31:0]     status_w;
  logic            drop;
  logic            bus_hold_q;
  logic            wr_hit;
  logic            a_prev_q;
  logic            b_prev_q;

  // Button synchronisers with falling-edge detect. Both idle high, so
  // a button held through reset shows one falling edge after release
  sor_fall_sync u_rst_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (reset_button),
    .level (rst_lvl),
    .fall  (rst_fall)
  );

  sor_fall_sync u_ack_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (ack_button),
    .level (ack_lvl),
    .fall  (ack_fall)
  );

  // Serial request bit falling edges
  assign ser_ack = req_ack_prev_q & ~ctrl_q[sor_pkg::CTRL_REQ_ACK];
  assign ser_rst = req_rst_prev_q & ~ctrl_q[sor_pkg::CTRL_REQ_RST];
  assign guard_open = ~actuated;

  // Either acknowledge source clears the discrepancy error; a new hit
  // in the same cycle wins, so a standing fault cannot be waved away
  assign disc_clr = ack_fall | ser_ack;

  // Retained discrepancy error flag
  sor_nv_flag u_disc_flag (
    .clk    (clk),
    .rst_n  (rst_n),
    .nv_in  (nv_disc_err),
    .set    (disc_hit),
    .clr    (disc_clr),
    .flag   (disc_err),
    .nv_out ()
  );

  // Serial request history; the request bits only act on their fall,
  // so a bit left high by software does nothing until it is lowered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ack_prev_q <= 1'b0;
      req_rst_prev_q <= 1'b0;
    end else begin
      req_ack_prev_q <= ctrl_q[sor_pkg::CTRL_REQ_ACK];
      req_rst_prev_q <= ctrl_q[sor_pkg::CTRL_REQ_RST];
    end
  end

  // Internal error latch, cleared by ser_rst or guard_open once cause gone; a cause that is
  // still present wins over the clear, so the error cannot be hidden
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      int_err_q <= 1'b0;
    end else if (internal_fault) begin
      int_err_q <= 1'b1;
    end else if (ser_rst || guard_open) begin
      int_err_q <= 1'b0;
    end
  end

  // Discrepancy timer between the two input drops. It starts at one on
  // the first drop, holds at the limit and clears whenever the inputs
  // agree again, so a paired drop within the limit never flags an error
  assign drop = (a_prev_q & ~safety_input_a) | (b_prev_q & ~safety_input_b);
  assign disc_hit = disc_run_q && disc_cnt_q == DW'(DISC_LIMIT)
                    && ctrl_q[sor_pkg::CTRL_DISC_EN];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_prev_q   <= 1'b1;
      b_prev_q   <= 1'b1;
      disc_run_q <= 1'b0;
      disc_cnt_q <= '0;
    end else begin
      a_prev_q <= safety_input_a;
      b_prev_q <= safety_input_b;
      if (safety_input_a == safety_input_b) begin
        disc_run_q <= 1'b0;
        disc_cnt_q <= '0;
      end else if (!disc_run_q && drop) begin
        disc_run_q <= 1'b1;
        disc_cnt_q <= DW'(1);
      end else if (disc_run_q && disc_cnt_q != DW'(DISC_LIMIT)) begin
        disc_cnt_q <= disc_cnt_q + DW'(1);
      end
    end
  end

  // Release conditions per variant. The monitored variant needs a fresh
  // falling edge of the reset button; holding it down does not re-arm
  assign may_release = actuated & safety_input_a & safety_input_b
                       & ~disc_err & ~disc_hit & ~int_err_q;
  assign go = ctrl_q[sor_pkg::CTRL_MONITORED]
              ? (feedback_closed & rst_fall)
              : feedback_closed;

  // Release state machine. A stored error parks it in the fault state,
  // and it only leaves once every error is gone; release then needs a
  // new go from the locked state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sor_pkg::SOR_LOCKED;
    end else begin
      unique case (state_q)
        sor_pkg::SOR_LOCKED: begin
          if (disc_err || int_err_q)
            state_q <= sor_pkg::SOR_FAULT;
          else if (may_release && go)
            state_q <= sor_pkg::SOR_RELEASED;
        end
        sor_pkg::SOR_RELEASED: begin
          if (disc_hit || int_err_q)
            state_q <= sor_pkg::SOR_FAULT;
          else if (!may_release)
            state_q <= sor_pkg::SOR_LOCKED;
        end
        sor_pkg::SOR_FAULT: begin
          if (!disc_err && !int_err_q)
            state_q <= sor_pkg::SOR_LOCKED;
        end
        default: state_q <= sor_pkg::SOR_LOCKED;
      endcase
    end
  end

  // Next output level, shared by both channels so they cannot disagree;
  // losing a release condition or a discrepancy hit drops it at once
  assign out_d = state_q == sor_pkg::SOR_RELEASED && may_release
                 && !disc_hit;

  // Safety outputs registered from the shared next level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      safety_output_a <= 1'b0;
      safety_output_b <= 1'b0;
    end else begin
      safety_output_a <= out_d;
      safety_output_b <= out_d;
    end
  end

  // Indicator blink divider, steady while released. The divider runs
  // free, so the first half period after a lock may be short
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_cnt_q <= '0;
      blink_q     <= 1'b0;
      status_led  <= 1'b0;
    end else begin
      if (blink_cnt_q == BW'(BLINK_HALF - 1)) begin
        blink_cnt_q <= '0;
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + BW'(1);
      end
      status_led <= (state_q == sor_pkg::SOR_RELEASED) ? 1'b1 : blink_q;
    end
  end

  // Retained error write-back, one cycle behind the flag; storage
  // commits whatever stands here, including the cleared state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      nv_disc_err_w <= 1'b0;
    else
      nv_disc_err_w <= disc_err;
  end

  // Interrupt events; release and off come from the output change about
  // to happen so that each fires once, in the cycle the outputs switch
  assign ev[sor_pkg::EV_RELEASE] = out_d & ~safety_output_a;
  assign ev[sor_pkg::EV_DISC]    = disc_hit;
  assign ev[sor_pkg::EV_OFF]     = safety_output_a & ~out_d;
  assign ev[sor_pkg::EV_W]       = disc_clr;

  // Writes land in the second cycle of a request, the one in which the
  // master sees waitrequest low; the first cycle only starts the answer
  assign wr_hit = avs_write && bus_hold_q && avs_byteenable[0];

  // Sticky interrupt status, set wins over write-one-clear, so an event
  // in the clearing cycle is never lost
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= '0;
    end else if (wr_hit && avs_address == sor_pkg::OFF_IRQ_ST) begin
      irq_st_q <= (irq_st_q & ~avs_writedata[3:0]) | ev;
    end else begin
      irq_st_q <= irq_st_q | ev;
    end
  end

  // Level interrupt, one cycle behind the sticky status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_st_q & irq_mk_q);
  end

  // Control and mask registers. A write with the low byte lane off is
  // ignored, since every field lives in that lane
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q   <= sor_pkg::CTRL_RESET;
      irq_mk_q <= '0;
    end else if (wr_hit) begin
      if (avs_address == sor_pkg::OFF_CTRL)
        ctrl_q <= avs_writedata[4:0];
      if (avs_address == sor_pkg::OFF_IRQ_MK)
        irq_mk_q <= avs_writedata[3:0];
    end
  end

  // Status word: output state, error latches and serial warning
  always_comb begin
    status_w                        = '0;
    status_w[sor_pkg::ST_OUT_ON]    = safety_output_a;
    status_w[sor_pkg::ST_DISC_ERR]  = disc_err;
    status_w[sor_pkg::ST_INT_ERR]   = int_err_q;
    status_w[sor_pkg::ST_WARN_COMM] =
      ctrl_q[sor_pkg::CTRL_COMM_ERR];
  end

  // Bus answer: one wait cycle, then data with waitrequest low. The
  // busy flag blocks a second start while the master still holds the
  // request at the answering edge; read data are captured on the first
  // cycle and stand while waitrequest is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_hold_q      <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= '0;
    end else begin
      bus_hold_q      <= (avs_read || avs_write) && !bus_hold_q;
      avs_waitrequest <= !((avs_read || avs_write) && !bus_hold_q);
      avs_readdata    <= '0;
      if (avs_read && !bus_hold_q) begin
        unique case (avs_address)
          sor_pkg::OFF_CTRL:   avs_readdata <= {27'h0, ctrl_q};
          sor_pkg::OFF_STATUS: avs_readdata <= status_w;
          sor_pkg::OFF_IRQ_ST: avs_readdata <= {28'h0, irq_st_q};
          sor_pkg::OFF_IRQ_MK: avs_readdata <= {28'h0, irq_mk_q};
          default:             avs_readdata <= '0;
        endcase
      end
    end
  end

  // Levels kept for debug visibility of the synchronisers; only the
  // edges drive the logic, so the levels go nowhere else
  logic unused_lvls;
  assign unused_lvls = rst_lvl ^ ack_lvl;
endmodule

// ===== rtl/sor_pkg.sv
// Purpose: Shared constants for the safety output release block
// Assumes: 125 MHz clock, Avalon-MM register access
// Notes:   Offsets are byte addresses of aligned 32-bit words
package sor_pkg;
  // Register byte offsets
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_STATUS = 4'h4;
  localparam logic [3:0] OFF_IRQ_ST = 4'h8;
  localparam logic [3:0] OFF_IRQ_MK = 4'hc;
  // Control bit positions
  localparam int CTRL_MONITORED = 0;
  localparam int CTRL_DISC_EN   = 1;
  localparam int CTRL_REQ_ACK   = 2;  // request byte bit 6 copy
  localparam int CTRL_REQ_RST   = 3;  // request byte bit 7 copy
  localparam int CTRL_COMM_ERR  = 4;  // warning byte bit 6 source
  localparam logic [4:0] CTRL_RESET = 5'h00;
  // Status bit positions
  localparam int ST_OUT_ON    = 0;
  localparam int ST_DISC_ERR  = 1;
  localparam int ST_INT_ERR   = 2;
  localparam int ST_WARN_COMM = 6;
  // Interrupt event bit positions
  localparam int EV_RELEASE = 0;
  localparam int EV_DISC    = 1;
  localparam int EV_OFF     = 2;
  localparam int EV_W       = 3;
  // Timing
  localparam int CLK_HZ        = 125_000_000;
  localparam int BLINK_HZ      = 5;
  localparam int DISC_TIME_MS  = 500;
  localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int DISC_CYC = (CLK_HZ / 1000) * DISC_TIME_MS;
  // Release states
  typedef enum logic [1:0] {SOR_LOCKED, SOR_RELEASED, SOR_FAULT}
    sor_state_t;
endpackage

// ===== rtl/sor_fall_sync.sv
// Purpose: Synchronise an input and flag its falling edge
// Assumes: Input idles high
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module sor_fall_sync (
  input  wire logic clk,     // System clock
  input  wire logic rst_n,   // Async reset, active low
  input  wire logic din,     // Raw input
  output logic      level,   // Synchronised level
  output logic      fall     // One-cycle falling edge pulse
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Two-stage synchroniser plus edge history
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign fall  = prev_q & ~sync_q;
endmodule

// ===== rtl/sor_nv_flag.sv
// Purpose: Stand-in for a non-volatile error flag cell
// Assumes: Stored value survives rst_n; loaded at reset release
// Notes:   nv_in is the retained cell value seen at power-up
`timescale 1ns/1ps
module sor_nv_flag (
  input  wire logic clk,     // System clock
  input  wire logic rst_n,   // Async reset, active low
  input  wire logic nv_in,   // Retained value from storage
  input  wire logic set,     // Store an error
  input  wire logic clr,     // Erase the error
  output logic      flag,    // Current flag, registered
  output logic      nv_out   // Value to commit to storage
);
  logic loaded_q;

  // Load the retained value once after release, set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      loaded_q <= 1'b0;
      flag     <= 1'b1;
    end else if (!loaded_q) begin
      loaded_q <= 1'b1;
      flag     <= nv_in | set;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end

  assign nv_out = flag;
endmodule

// ===== tb/sor_release_props.sv
// Purpose: Port checks for the safety output release block
// Assumes: One clock domain, rst_n async active low
// Notes:   Bound to every sor_release instance
`timescale 1ns/1ps
module sor_release_props #(
  parameter int BLINK_HALF = 4,
  parameter int DISC_LIMIT = 20
) (
  input wire logic clk,             // Clock
  input wire logic rst_n,           // Reset, active low
  input wire logic safety_input_a,  // Input A
  input wire logic safety_input_b,  // Input B
  input wire logic actuated,        // Guard closed
  input wire logic nv_disc_err_w,   // Stored error
  input wire logic safety_output_a, // Output A
  input wire logic safety_output_b, // Output B
  input wire logic status_led,      // Indicator
  input wire logic avs_read,        // Read strobe
  input wire logic avs_write,       // Write strobe
  input wire logic avs_waitrequest  // Wait request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic led_q;
  int   still_q;
  int   apart_q;
  // Indicator hold time while locked, and time inputs disagree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_q   <= 1'b0;
      still_q <= 0;
      apart_q <= 0;
    end else begin
      led_q   <= status_led;
      still_q <= (safety_output_a || status_led != led_q) ? 0 : still_q + 1;
      apart_q <= (safety_input_a != safety_input_b) ? apart_q + 1 : 0;
    end
  end
  out_pair_a: assert property (safety_output_a == safety_output_b)
    else $error("safety outputs disagree");
  led_steady_a: assert property (
    safety_output_a && $past(safety_output_a, 2) |-> status_led)
    else $error("indicator not steady while released");
  led_blink_a: assert property (still_q <= BLINK_HALF + 3)
    else $error("indicator stopped blinking while locked");
  release_cond_a: assert property ($rose(safety_output_a) |->
    $past(actuated) && $past(safety_input_a) && $past(safety_input_b))
    else $error("release without closed guard and live inputs");
  inputs_off_a: assert property (
    !safety_input_a && !safety_input_b |-> ##[1:3] !safety_output_a)
    else $error("outputs stay on with both inputs dropped");
  disc_off_a: assert property (
    $rose(nv_disc_err_w) |-> ##[0:2] !safety_output_a)
    else $error("outputs on after discrepancy");
  disc_time_a: assert property (
    $rose(nv_disc_err_w) && safety_input_a != safety_input_b |->
    apart_q >= DISC_LIMIT && apart_q <= DISC_LIMIT + 4)
    else $error("discrepancy flagged at wrong time");
  err_block_a: assert property (
    nv_disc_err_w && $past(nv_disc_err_w) |-> !$rose(safety_output_a))
    else $error("release with unacknowledged error");
  wait_bound_a: assert property (
    (avs_read || avs_write) |-> ##[0:3] !avs_waitrequest)
    else $error("bus answer late");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  cover property ($rose(safety_output_a));
  cover property ($rose(nv_disc_err_w));
  cover property ($fell(nv_disc_err_w));
endmodule

bind sor_release sor_release_props #(
  .BLINK_HALF(BLINK_HALF),
  .DISC_LIMIT(DISC_LIMIT)
) props_u (.*);

// ===== tb/sor_field.sv
// Purpose: Operator buttons in front of the release block
// Assumes: Buttons idle high
// Notes:   Acknowledge press lasts six cycles
`timescale 1ns/1ps
module sor_field (
  input  wire logic clk,          // Clock
  input  wire logic rst_n,        // Reset, active low
  input  wire logic hold_rst,     // Keep reset button pressed
  input  wire logic press_ack,    // Start an acknowledge press
  output logic      reset_button, // Reset button
  output logic      ack_button    // Acknowledge button
);
  logic [2:0] ack_cnt_q;
  // Reset button follows the hand
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) reset_button <= 1'b1;
    else reset_button <= !hold_rst;
  end
  // Press long enough to pass the synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ack_cnt_q <= 3'h0;
    else if (press_ack) ack_cnt_q <= 3'h6;
    else if (ack_cnt_q != 3'h0) ack_cnt_q <= ack_cnt_q - 3'h1;
  end
  assign ack_button = (ack_cnt_q == 3'h0);
endmodule

// ===== tb/tb.sv
// Purpose: Self-checking bench for the safety output release block
// Assumes: Short blink and discrepancy counts
// Notes:   Register rows first, then sequences
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, safety_input_a, safety_input_b, actuated;
  logic feedback_closed, reset_button, ack_button, internal_fault;
  logic nv_disc_err, nv_disc_err_w, safety_output_a, safety_output_b;
  logic status_led, irq, avs_read, avs_write, avs_waitrequest;
  logic hold_rst, press_ack, led0;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  int mismatches, checks, tog;
  typedef struct {logic w; logic [3:0] a; logic [31:0] d;} sor_row_t;
  sor_row_t rows [8] = '{'{1'b1, 4'hc, 32'hf}, '{1'b0, 4'hc, 32'hf},
    '{1'b1, 4'h8, 32'hf}, '{1'b0, 4'h8, 32'h0}, '{1'b1, 4'h0, 32'h10},
    '{1'b0, 4'h4, 32'h40}, '{1'b1, 4'h0, 32'h0}, '{1'b0, 4'h2, 32'h0}};

  sor_release #(.BLINK_HALF(4), .DISC_LIMIT(20)) dut_u (.*);
  sor_field field_u (.*);

  // Clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      mismatches++;
      complete_run();
    end
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wait_out(input logic v);
    int n;
    n = 0;
    while (safety_output_a !== v && n < 60) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, safety_output_a}, {31'h0, v});
    if (safety_output_a !== v) complete_run();
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    complete_run();
  end

  // Main sequence
  initial begin
    {rst_n, actuated, feedback_closed, internal_fault, nv_disc_err} = 5'h0;
    {safety_input_a, safety_input_b} = 2'h3;
    {avs_read, avs_write, hold_rst, press_ack} = 4'h0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(q, rows[i].d);
    end
    led0 = status_led;
    tog = 0;
    repeat (16) begin
      @(posedge clk);
      if (status_led !== led0) tog++;
      led0 = status_led;
    end
    chk({31'h0, tog >= 3 && tog <= 5 && !safety_output_a}, 32'h1);
    actuated <= 1'b1;
    feedback_closed <= 1'b1;
    wait_out(1'b1);
    repeat (3) @(posedge clk);
    chk({30'h0, safety_output_b, status_led}, 32'h3);
    rd(4'h4, 32'h1);
    rd(4'h8, 32'h1);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, 4'h8, 32'h1);
    bus(1'b1, 4'hc, 32'h2);
    chk({31'h0, irq}, 32'h0);
    actuated <= 1'b0;
    wait_out(1'b0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(4'h8, 32'h4);
    bus(1'b1, 4'h8, 32'h4);
    bus(1'b1, 4'h0, 32'h1);
    actuated <= 1'b1;
    repeat (30) @(posedge clk);
    chk({31'h0, safety_output_a}, 32'h0);
    hold_rst <= 1'b1;
    wait_out(1'b1);
    actuated <= 1'b0;
    wait_out(1'b0);
    actuated <= 1'b1;
    repeat (30) @(posedge clk);
    chk({31'h0, safety_output_a}, 32'h0);
    hold_rst <= 1'b0;
    bus(1'b1, 4'h0, 32'h2);
    wait_out(1'b1);
    safety_input_a <= 1'b0;
    repeat (5) @(posedge clk);
    safety_input_b <= 1'b0;
    wait_out(1'b0);
    repeat (30) @(posedge clk);
    chk({31'h0, nv_disc_err_w}, 32'h0);
    {safety_input_a, safety_input_b} <= 2'h3;
    wait_out(1'b1);
    safety_input_a <= 1'b0;
    repeat (15) @(posedge clk);
    chk({30'h0, safety_output_a, nv_disc_err_w}, 32'h0);
    repeat (10) @(posedge clk);
    wait_out(1'b0);
    chk({30'h0, nv_disc_err_w, irq}, 32'h3);
    rd(4'h4, 32'h2);
    safety_input_a <= 1'b1;
    repeat (30) @(posedge clk);
    chk({31'h0, safety_output_a}, 32'h0);
    press_ack <= 1'b1;
    @(posedge clk);
    press_ack <= 1'b0;
    wait_out(1'b1);
    safety_input_a <= 1'b0;
    wait_out(1'b0);
    safety_input_a <= 1'b1;
    nv_disc_err <= 1'b1;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({31'h0, nv_disc_err_w}, 32'h1);
    rd(4'h4, 32'h2);
    nv_disc_err <= 1'b0;
    repeat (20) @(posedge clk);
    chk({31'h0, safety_output_a}, 32'h0);
    bus(1'b1, 4'h0, 32'h4);
    bus(1'b1, 4'h0, 32'h0);
    wait_out(1'b1);
    chk({31'h0, nv_disc_err_w}, 32'h0);
    internal_fault <= 1'b1;
    wait_out(1'b0);
    internal_fault <= 1'b0;
    repeat (5) @(posedge clk);
    rd(4'h4, 32'h4);
    bus(1'b1, 4'h0, 32'h8);
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b0, 4'h4, 32'h0);
    chk({31'h0, q[2]}, 32'h0);
    complete_run();
  end
endmodule
